//--- design/diag_parser_pkg.sv
// constants and types for the channel diagnosis entry parser
package diag_parser_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_INT_STAT = 8'h08;
  localparam logic [7:0] OFF_INT_MASK = 8'h0C;
  localparam logic [7:0] OFF_ENTRY    = 8'h10;
  localparam logic [7:0] OFF_BMAP_LO  = 8'h14;
  localparam logic [7:0] OFF_BMAP_HI  = 8'h18;
  localparam logic [7:0] OFF_COUNT    = 8'h1C;

  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // interrupt status / mask bit positions
  localparam int IRQ_ENTRY  = 0;
  localparam int IRQ_TRUNC  = 1;
  localparam int IRQ_BITMAP = 2;
  localparam int IRQ_VENDOR = 3;
  localparam int IRQ_W      = 4;

  // byte marker patterns in bits 7:6
  localparam logic [1:0] MARK_IDENT   = 2'b01;
  localparam logic [1:0] MARK_CHANNEL = 2'b10;

  // fault cause codes
  localparam logic [4:0] FAULT_FIRST_STD  = 5'h01;
  localparam logic [4:0] FAULT_LAST_STD   = 5'h09;
  localparam logic [4:0] FAULT_FIRST_VEND = 5'h10;

  localparam int MODULES     = 64;
  localparam int BITMAP_BYTES = MODULES / 8;

  typedef enum logic [2:0] {
    ST_HDR    = 3'b000,
    ST_BITMAP = 3'b001,
    ST_CH0    = 3'b010,
    ST_CH1    = 3'b011,
    ST_CH2    = 3'b100,
    ST_DONE   = 3'b101
  } parse_state_t;

  typedef enum logic [1:0] {
    FC_RESERVED = 2'b00,
    FC_STANDARD = 2'b01,
    FC_VENDOR   = 2'b10
  } fault_class_t;

endpackage

//--- design/channel_diag_entry_parser.sv
// extended diagnosis byte parser: identifier bitmap and channel entries, with apb registers
// Behaviour
// - channel block is decoded as successive three-byte entries until a non-entry byte
// - entry byte 0: module number bits 5:0, bit 6 zero, bit 7 one
// - entry byte 1: channel number bits 5:0, bit 6 input, bit 7 output
// - byte 2 bits 4:0 codes 1..9 are the listed fault causes
// - fault code 0 and 10..15 reserved, 16..31 vendor specific
// - byte 2 bits 7:5 give channel data type, 1 bit to two words
// - data type is reported only, never used on configuration identifiers
// - bitmap byte 2 bit 0 flags module 9, upward from there
// - identifier header: length with header in bits 5:0, bit 6 one, bit 7 zero
// - bitmap byte 1 bit 0 flags module 1, one bit per module in order
`timescale 1ns/1ps
`default_nettype none
module channel_diag_entry_parser
  import diag_parser_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              byte_valid,
  input  wire logic              byte_first,
  input  wire logic [7:0]        extended_diag_bytes,
  output logic                   entry_valid,
  output logic [5:0]             entry_module,
  output logic [5:0]             entry_channel,
  output logic                   entry_input,
  output logic                   entry_output,
  output logic [4:0]             entry_fault,
  output fault_class_t           entry_fault_class,
  output logic [2:0]             entry_dtype,
  output logic [5:0]             entry_dtype_bits,
  output logic                   irq
);

  parse_state_t st_r;
  logic [31:0]  ctrl_r;
  logic [IRQ_W-1:0] int_stat_r;
  logic [IRQ_W-1:0] int_mask_r;
  logic [IRQ_W-1:0] int_set;
  logic [5:0]   bm_left_r;
  logic [2:0]   bm_idx_r;
  logic [MODULES-1:0] module_bitmap_r;
  logic [5:0]   mod_hold_r;
  logic [5:0]   chan_hold_r;
  logic         in_hold_r;
  logic         out_hold_r;
  logic [15:0]  count_r;
  logic         take;
  logic         wr_en;
  logic         rd_sel;
  logic         mapped;
  logic [7:0]   b;
  logic [4:0]   fault_code;
  logic [2:0]   dtype_code;

  assign b          = extended_diag_bytes;
  assign take       = byte_valid && ctrl_r[CTRL_EN_BIT];
  assign fault_code = b[4:0];
  assign dtype_code = b[7:5];

  // parse sequencer; while ctrl enable is set, a first byte always restarts, even mid-entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= ST_HDR;
      bm_left_r <= 6'd0;
      bm_idx_r  <= 3'd0;
    end else if (take) begin
      if (byte_first) begin
        bm_idx_r <= 3'd0;
        if (b[7:6] == MARK_IDENT) begin
          bm_left_r <= b[5:0] - 6'd1;
          st_r      <= (b[5:0] <= 6'd1) ? ST_CH0 : ST_BITMAP;
        end else begin
          st_r <= ST_DONE;
        end
      end else begin
        case (st_r)
          ST_BITMAP: begin
            bm_left_r <= bm_left_r - 6'd1;
            if (bm_idx_r != 3'd7) begin
              bm_idx_r <= bm_idx_r + 3'd1;
            end
            if (bm_left_r == 6'd1) begin
              st_r <= ST_CH0;
            end
          end
          ST_CH0: begin
            // any byte without the entry marker closes the channel block
            st_r <= (b[7:6] == MARK_CHANNEL) ? ST_CH1 : ST_DONE;
          end
          ST_CH1: begin
            st_r <= ST_CH2;
          end
          ST_CH2: begin
            st_r <= ST_CH0;
          end
          ST_HDR, ST_DONE: begin
            st_r <= st_r;
          end
          default: begin
            st_r <= ST_DONE;
          end
        endcase
      end
    end
  end

  // module bitmap, bit k set means module k+1 has diagnosis
  // bytes past the eighth cannot name a module below 65 and are dropped
  logic [3:0] bm_extra_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bm_extra_r <= 4'd0;
    end else if (take && byte_first) begin
      bm_extra_r <= 4'd0;
    end else if (take && st_r == ST_BITMAP && bm_idx_r == 3'd7 && bm_extra_r != 4'hF) begin
      bm_extra_r <= bm_extra_r + 4'd1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < MODULES; gi++) begin : g_bmap
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          module_bitmap_r[gi] <= 1'b0;
        end else if (take && byte_first) begin
          module_bitmap_r[gi] <= 1'b0;
        end else if (take && st_r == ST_BITMAP && bm_extra_r == 4'd0 &&
                     bm_idx_r == 3'(gi / 8)) begin
          module_bitmap_r[gi] <= b[gi % 8];
        end
      end
    end
  endgenerate

  // first two entry bytes held until the third completes the entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_hold_r  <= 6'd0;
      chan_hold_r <= 6'd0;
      in_hold_r   <= 1'b0;
      out_hold_r  <= 1'b0;
    end else if (take && !byte_first) begin
      if (st_r == ST_CH0 && b[7:6] == MARK_CHANNEL) begin
        mod_hold_r <= b[5:0];
      end
      if (st_r == ST_CH1) begin
        chan_hold_r <= b[5:0];
        in_hold_r   <= b[6];
        out_hold_r  <= b[7];
      end
    end
  end

  // entry outputs; data type only feeds the report, never the bitmap or identifiers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_valid       <= 1'b0;
      entry_module      <= 6'd0;
      entry_channel     <= 6'd0;
      entry_input       <= 1'b0;
      entry_output      <= 1'b0;
      entry_fault       <= 5'd0;
      entry_fault_class <= FC_RESERVED;
      entry_dtype       <= 3'd0;
      entry_dtype_bits  <= 6'd0;
    end else begin
      entry_valid <= take && !byte_first && st_r == ST_CH2;
      if (take && !byte_first && st_r == ST_CH2) begin
        entry_module  <= mod_hold_r;
        entry_channel <= chan_hold_r;
        entry_input   <= in_hold_r;
        entry_output  <= out_hold_r;
        entry_fault   <= fault_code;
        if (fault_code >= FAULT_FIRST_VEND) begin
          entry_fault_class <= FC_VENDOR;
        end else if (fault_code >= FAULT_FIRST_STD && fault_code <= FAULT_LAST_STD) begin
          entry_fault_class <= FC_STANDARD;
        end else begin
          entry_fault_class <= FC_RESERVED;
        end
        entry_dtype <= dtype_code;
        case (dtype_code)
          3'd1:    entry_dtype_bits <= 6'd1;
          3'd2:    entry_dtype_bits <= 6'd2;
          3'd3:    entry_dtype_bits <= 6'd4;
          3'd4:    entry_dtype_bits <= 6'd8;
          3'd5:    entry_dtype_bits <= 6'd16;
          3'd6:    entry_dtype_bits <= 6'd32;
          default: entry_dtype_bits <= 6'd0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 16'h0000;
    end else if (entry_valid && count_r != 16'hFFFF) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // interrupt events
  always_comb begin
    int_set             = '0;
    int_set[IRQ_ENTRY]  = take && !byte_first && st_r == ST_CH2;
    int_set[IRQ_TRUNC]  = take && byte_first && (st_r == ST_CH1 || st_r == ST_CH2 || st_r == ST_BITMAP);
    int_set[IRQ_BITMAP] = take && !byte_first && st_r == ST_BITMAP && b != 8'h00;
    int_set[IRQ_VENDOR] = int_set[IRQ_ENTRY] && fault_code >= FAULT_FIRST_VEND;
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_sel = psel && !pwrite;

  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr[7:0])
      OFF_CTRL:     prdata = ctrl_r;
      OFF_STATUS:   prdata = {29'd0, st_r};
      OFF_INT_STAT: prdata = {28'd0, int_stat_r};
      OFF_INT_MASK: prdata = {28'd0, int_mask_r};
      OFF_ENTRY:    prdata = {entry_dtype, entry_fault, entry_output, entry_input, 2'b00,
                              entry_channel, 8'd0, entry_module};
      OFF_BMAP_LO:  prdata = module_bitmap_r[31:0];
      OFF_BMAP_HI:  prdata = module_bitmap_r[63:32];
      OFF_COUNT:    prdata = {16'd0, count_r};
      default:      mapped = 1'b0;
    endcase
    if (!rd_sel) begin
      prdata = 32'h0000_0000;
    end
  end
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= CTRL_RESET;
      int_mask_r <= '0;
    end else if (wr_en) begin
      if (paddr[7:0] == OFF_CTRL) begin
        ctrl_r <= {31'd0, pwdata[CTRL_EN_BIT]};
      end
      if (paddr[7:0] == OFF_INT_MASK) begin
        int_mask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= '0;
    end else if (wr_en && paddr[7:0] == OFF_INT_STAT) begin
      int_stat_r <= (int_stat_r & ~pwdata[IRQ_W-1:0]) | int_set;
    end else begin
      int_stat_r <= int_stat_r | int_set;
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  // checks
  sequence third_byte_s;
    st_r == ST_CH2 && take && !byte_first;
  endsequence

  sequence entry_start_s;
    st_r == ST_CH0 && take && !byte_first && b[7:6] == MARK_CHANNEL;
  endsequence

  entry_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    third_byte_s |=> entry_valid ##1 !entry_valid)
    else $error("entry strobe missing or too long");

  entry_walk_a: assert property (@(posedge pclk) disable iff (!presetn)
    entry_start_s ##1 (take && !byte_first) ##1 third_byte_s |=> entry_valid && st_r == ST_CH0)
    else $error("three-byte entry not completed");

  module_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    entry_start_s |=> st_r == ST_CH1 && mod_hold_r == $past(b[5:0]))
    else $error("module number not captured");

  channel_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == ST_CH1 && take && !byte_first) |=>
      chan_hold_r == $past(b[5:0]) && in_hold_r == $past(b[6]) && out_hold_r == $past(b[7]))
    else $error("channel or direction not captured");

  fault_std_a: assert property (@(posedge pclk) disable iff (!presetn)
    entry_valid && entry_fault >= 5'd1 && entry_fault <= 5'd9 |-> entry_fault_class == FC_STANDARD)
    else $error("listed fault not classed standard");

  fault_other_a: assert property (@(posedge pclk) disable iff (!presetn)
    entry_valid |-> (entry_fault[4] ? (entry_fault_class == FC_VENDOR) :
                    (!(entry_fault == 5'd0 || entry_fault >= 5'd10) || entry_fault_class == FC_RESERVED)))
    else $error("reserved or vendor fault misclassed");

  dtype_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    third_byte_s and (b[7:5] == 3'd6) |=> entry_dtype_bits == 6'd32 && entry_dtype == 3'd6)
    else $error("two-word data type not decoded");

  bitmap_nine_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == ST_BITMAP && take && !byte_first && bm_idx_r == 3'd1 && bm_extra_r == 4'd0) |=>
      module_bitmap_r[8] == $past(b[0]))
    else $error("module 9 bit misplaced");

  header_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && byte_first && b[7:6] == MARK_IDENT && b[5:0] == 6'd2) |=>
      st_r == ST_BITMAP && bm_left_r == 6'd1)
    else $error("header length not honoured");

  irq_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    third_byte_s and (int_mask_r[IRQ_ENTRY] && !wr_en) |=> irq)
    else $error("entry interrupt not raised");

endmodule
`default_nettype wire

//--- sim/diag_slave_model.sv
// remote slave model sending extended diagnosis bytes
`timescale 1ns/1ps
`default_nettype none
module diag_slave_model (
  input  wire logic       pclk,
  output logic            byte_valid,
  output logic            byte_first,
  output logic [7:0]      extended_diag_bytes
);
  initial begin
    byte_valid = 1'b0;
    byte_first = 1'b0;
    extended_diag_bytes = 8'h00;
  end
  task automatic put(input logic f, input logic [7:0] b);
    @(posedge pclk);
    byte_valid <= 1'b1;
    byte_first <= f;
    extended_diag_bytes <= b;
  endtask
  // line is not driven between bytes: show the inverse, not a stale byte
  task automatic idle();
    @(posedge pclk);
    byte_valid <= 1'b0;
    byte_first <= 1'b0;
    extended_diag_bytes <= ~extended_diag_bytes;
  endtask
  task automatic header(input logic [5:0] len);
    put(1'b1, {2'b01, len});
  endtask
  task automatic entry(input logic [5:0] m, input logic [5:0] c, input logic i, input logic o,
                       input logic [7:0] b2);
    put(1'b0, {2'b10, m});
    put(1'b0, {o, i, c});
    put(1'b0, b2);
  endtask
endmodule
`default_nettype wire

//--- sim/test_channel_diag_entry_parser.sv
// bench for the channel diagnosis entry parser
`timescale 1ns/1ps
`default_nettype none
module test_channel_diag_entry_parser;
  import diag_parser_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, entry_valid, entry_input, entry_output, bv, bf;
  logic [7:0]  bd;
  logic [5:0]  entry_module, entry_channel, entry_dtype_bits;
  logic [4:0]  entry_fault;
  logic [2:0]  entry_dtype;
  fault_class_t entry_fault_class;
  logic [31:0] q[$];
  logic [31:0] rv;
  logic        ev;
  int          n_mismatch = 0;
  int          n_checks = 0;

  always #25 pclk = ~pclk;

  diag_slave_model slv (.pclk(pclk), .byte_valid(bv), .byte_first(bf), .extended_diag_bytes(bd));

  channel_diag_entry_parser dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .byte_valid(bv), .byte_first(bf), .extended_diag_bytes(bd), .entry_valid(entry_valid),
    .entry_module(entry_module), .entry_channel(entry_channel), .entry_input(entry_input),
    .entry_output(entry_output), .entry_fault(entry_fault), .entry_fault_class(entry_fault_class),
    .entry_dtype(entry_dtype), .entry_dtype_bits(entry_dtype_bits), .irq(irq)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, ev);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rv, ev);
    check(rv, exp);
  endtask

  // packed expectation for entry k: module 63-k, channel k, codes from k
  function automatic logic [31:0] exp_e(input int k);
    logic [4:0] f;
    logic [2:0] t;
    logic [1:0] cl;
    logic [5:0] bw;
    f = k[4:0];
    t = k[2:0];
    cl = (f == 0 || (f >= 10 && f <= 15)) ? 2'b00 : (f >= 16 ? 2'b10 : 2'b01);
    case (t)
      3'd1: bw = 6'd1;
      3'd2: bw = 6'd2;
      3'd3: bw = 6'd4;
      3'd4: bw = 6'd8;
      3'd5: bw = 6'd16;
      3'd6: bw = 6'd32;
      default: bw = 6'd0;
    endcase
    return {2'b00, 6'(63 - k), k[5:0], k[0], k[1], f, cl, t, bw};
  endfunction

  always @(posedge pclk) begin
    if (entry_valid === 1'b1) begin
      check({2'b00, entry_module, entry_channel, entry_input, entry_output, entry_fault,
             entry_fault_class, entry_dtype, entry_dtype_bits}, q.size() ? q.pop_front() : 32'hFFFF_FFFF);
    end
  end

  initial begin
    #200_000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check({30'h0, irq, entry_valid}, 32'h0000_0000);
    rd(OFF_CTRL, CTRL_RESET);
    rd(OFF_STATUS, 32'h0000_0000);
    rd(OFF_INT_MASK, 32'h0000_0000);
    rd(OFF_COUNT, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    check({31'h0, ev}, 32'h0000_0001);
    slv.header(6'd3);
    slv.put(1'b0, 8'h01);
    slv.put(1'b0, 8'h01);
    for (int k = 0; k < 32; k++) begin
      slv.entry(6'(63 - k), k[5:0], k[0], k[1], {k[2:0], k[4:0]});
      q.push_back(exp_e(k));
    end
    slv.put(1'b0, 8'h33);
    slv.idle();
    repeat (2) @(posedge pclk);
    rd(OFF_STATUS, 32'h0000_0005);
    rd(OFF_COUNT, 32'h0000_0020);
    check(q.size(), 32'h0000_0000);
    rd(OFF_BMAP_LO, 32'h0000_0101);
    rd(OFF_BMAP_HI, 32'h0000_0000);
    rd(OFF_INT_STAT, 32'h0000_000D);
    check({31'h0, irq}, 32'h0000_0000);
    wr(OFF_INT_MASK, 32'h0000_0001 << IRQ_VENDOR);
    // mask lands at the access edge; look once it has settled
    @(negedge pclk);
    check({31'h0, irq}, 32'h0000_0001);
    wr(OFF_INT_STAT, 32'h0000_0001 << IRQ_VENDOR);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0000_0000);
    rd(OFF_INT_STAT, 32'h0000_0005);
    slv.header(6'd2);
    slv.put(1'b0, 8'h00);
    slv.put(1'b0, 8'h81);
    slv.put(1'b0, 8'h00);
    slv.header(6'd1);
    slv.idle();
    rd(OFF_INT_STAT, 32'h0000_0007);
    wr(OFF_INT_STAT, 32'h0000_000F);
    wr(OFF_INT_MASK, 32'h0000_0001 << IRQ_ENTRY);
    wr(OFF_CTRL, 32'h0000_0000);
    slv.entry(6'd1, 6'd1, 1'b1, 1'b0, 8'h21);
    slv.idle();
    rd(OFF_INT_STAT, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0001);
    slv.entry(6'(63 - 9), 6'd9, 1'b1, 1'b0, 8'h29);
    q.push_back(exp_e(9));
    slv.idle();
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0000_0001);
    rd(OFF_ENTRY, 32'h2942_4036);
    rd(OFF_COUNT, 32'h0000_0021);
    check(q.size(), 32'h0000_0000);
    stop_test();
  end
endmodule
`default_nettype wire
